// file: core/sbsram_core.sv
`timescale 1ns/1ps
`default_nettype none
module sbsram_core (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic x18_mode_in,
    input wire logic [sbsram_pkg::ADDR_W-1:0] address_in,
    input wire logic processor_addr_strobe_n_in,
    input wire logic controller_addr_strobe_n_in,
    input wire logic burst_advance_n_in,
    input wire logic chip_sel_low_first_n_in,
    input wire logic chip_sel_pair_high_in,
    input wire logic chip_sel_pair_low_n_in,
    input wire logic global_write_n_in,
    input wire logic byte_write_gate_in,
    input wire logic [3:0] lane_write_n_in,
    input wire logic output_enable_n_in,
    input wire logic sleep_request_in,
    input wire logic burst_order_select_in,
    input wire logic [sbsram_pkg::DATA_W-1:0] dq_in,
    output logic [sbsram_pkg::DATA_W-1:0] dq_out,
    output logic [sbsram_pkg::DATA_W-1:0] dq_oe_n_out,
    output logic asleep_out
);
    // Storage is a plain array; there is no reset on it, so contents
    // read before the first write are unknown, as on the real part.
    // Burst state survives sleep because nothing here clears it.
    logic [sbsram_pkg::DATA_W-1:0] mem [0:sbsram_pkg::DEPTH-1];
    logic [sbsram_pkg::ADDR_W-1:0] base_addr, next_base_addr;
    logic [1:0] burst_cnt, next_burst_cnt;
    sbsram_pkg::sbs_op_e op, next_op;
    logic [sbsram_pkg::DATA_W-1:0] rd_stage, next_rd_stage;
    logic rd_valid, next_rd_valid;
    logic drive, next_drive;
    logic [1:0] sleep_cnt, next_sleep_cnt;
    logic asleep, next_asleep;
    logic [3:0] lane_we;
    logic write_n;
    logic selected, proc_start, ctrl_start, any_start, do_write, do_read;
    logic [1:0] low_bits;
    logic [sbsram_pkg::ADDR_W-1:0] access_addr;
    logic [sbsram_pkg::DATA_W-1:0] wr_mask;

    sbsram_lane_decode u_decode (
        .global_write_n_in(global_write_n_in),
        .byte_write_gate_in(byte_write_gate_in),
        .x18_mode_in(x18_mode_in),
        .lane_write_n_in(lane_write_n_in),
        .lane_we_out(lane_we),
        .write_n_out(write_n)
    );

    // Start decode; a strobe with a chip select inactive deselects.
    // The processor strobe is blocked when the first select is off, so
    // that case falls through to a continue beat instead of a deselect.
    // No start is taken while asleep; the far side must also keep the
    // strobes idle for two edges after the sleep request drops.
    always_comb begin
        selected = !chip_sel_low_first_n_in && chip_sel_pair_high_in && !chip_sel_pair_low_n_in;
        proc_start = !processor_addr_strobe_n_in && selected && !asleep;
        ctrl_start = !controller_addr_strobe_n_in && processor_addr_strobe_n_in && selected && !asleep;
        any_start = proc_start || ctrl_start;
    end

    // Burst order: linear adds, interleaved xors the count into the start bits
    always_comb begin
        low_bits = burst_order_select_in ? (base_addr[1:0] ^ burst_cnt) : (base_addr[1:0] + burst_cnt);
        access_addr = {base_addr[sbsram_pkg::ADDR_W-1:2], low_bits};
    end

    // Address, counter and operation sequencing.
    // Priority: sleep, processor start, controller start, deselect,
    // then continue or suspend of whatever burst is open.
    always_comb begin
        next_base_addr = base_addr;
        next_burst_cnt = burst_cnt;
        next_op = op;
        do_write = 1'b0;
        do_read = 1'b0;
        if (asleep) begin
            next_op = op;
        end else if (proc_start) begin
            next_base_addr = address_in;
            next_burst_cnt = 2'h0;
            next_op = sbsram_pkg::SBS_READ;
            do_read = 1'b1;
        end else if (ctrl_start) begin
            next_base_addr = address_in;
            next_burst_cnt = 2'h0;
            next_op = write_n ? sbsram_pkg::SBS_READ : sbsram_pkg::SBS_WRITE;
            do_read = write_n;
            do_write = !write_n;
        end else if ((!processor_addr_strobe_n_in || !controller_addr_strobe_n_in) && controller_addr_strobe_n_in
                     && !chip_sel_low_first_n_in) begin
            // Processor strobe with a pair select inactive deselects
            next_op = sbsram_pkg::SBS_IDLE;
        end else if (!controller_addr_strobe_n_in) begin
            next_op = sbsram_pkg::SBS_IDLE;
        end else if (op != sbsram_pkg::SBS_IDLE) begin
            // Continue or suspend; composite write picks the direction
            if (!burst_advance_n_in) begin
                next_burst_cnt = burst_cnt + 2'h1;
            end
            do_write = !write_n;
            do_read = write_n;
            next_op = write_n ? sbsram_pkg::SBS_READ : sbsram_pkg::SBS_WRITE;
        end
    end

    // Write path uses the start address on a start edge, else the burst address
    always_comb begin
        for (int i = 0; i < sbsram_pkg::LANES; i++) begin
            wr_mask[i*sbsram_pkg::LANE_W +: sbsram_pkg::LANE_W] = {sbsram_pkg::LANE_W{lane_we[i]}};
        end
    end

    // Array: the start edge of a burst accesses the external address itself
    always_ff @(posedge clock_in) begin
        if (do_write) begin
            if (ctrl_start) begin
                mem[address_in] <= (mem[address_in] & ~wr_mask) | (dq_in & wr_mask);
            end else begin
                mem[next_addr_of_step()] <= (mem[next_addr_of_step()] & ~wr_mask) | (dq_in & wr_mask);
            end
        end
    end

    function automatic logic [sbsram_pkg::ADDR_W-1:0] next_addr_of_step();
        logic [1:0] cnt;
        logic [1:0] lb;
        cnt = burst_advance_n_in ? burst_cnt : burst_cnt + 2'h1;
        lb = burst_order_select_in ? (base_addr[1:0] ^ cnt) : (base_addr[1:0] + cnt);
        return {base_addr[sbsram_pkg::ADDR_W-1:2], lb};
    endfunction

    // Read pipeline: array to output register, then to the output buffer.
    // Suspended reads refill the same word each cycle, so the output
    // buffer keeps showing it until the burst moves on.
    always_comb begin
        next_rd_stage = rd_stage;
        next_rd_valid = 1'b0;
        if (do_read) begin
            next_rd_stage = any_start ? mem[address_in] : mem[next_addr_of_step()];
            next_rd_valid = 1'b1;
        end
        next_drive = rd_valid && !asleep;
    end

    // Sleep latency counter; entry and exit limits are kept apart so
    // either latency can change alone. A request that drops before the
    // count completes restarts the count from zero.
    always_comb begin
        next_sleep_cnt = 2'h0;
        next_asleep = asleep;
        if (sleep_request_in != asleep) begin
            next_sleep_cnt = sleep_cnt + 2'h1;
            if (asleep) begin
                if (sleep_cnt == 2'(sbsram_pkg::SLEEP_EXIT_CYCLES - 1)) begin
                    next_asleep = 1'b0;
                    next_sleep_cnt = 2'h0;
                end
            end else if (sleep_cnt == 2'(sbsram_pkg::SLEEP_ENTRY_CYCLES - 1)) begin
                next_asleep = 1'b1;
                next_sleep_cnt = 2'h0;
            end
        end
    end

    // Registers; memory contents and burst state survive sleep
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            base_addr <= '0;
            burst_cnt <= 2'h0;
            op <= sbsram_pkg::SBS_IDLE;
            rd_stage <= '0;
            rd_valid <= 1'b0;
            drive <= 1'b0;
            sleep_cnt <= 2'h0;
            asleep <= 1'b0;
            dq_out <= '0;
            dq_oe_n_out <= '1;
            asleep_out <= 1'b0;
        end else begin
            base_addr <= next_base_addr;
            burst_cnt <= next_burst_cnt;
            op <= next_op;
            rd_stage <= next_rd_stage;
            rd_valid <= next_rd_valid;
            drive <= next_drive;
            sleep_cnt <= next_sleep_cnt;
            asleep <= next_asleep;
            asleep_out <= next_asleep;
            if (rd_valid) begin
                dq_out <= rd_stage;
            end
            // Enable is registered, so output enable and sleep act one edge late
            dq_oe_n_out <= {sbsram_pkg::DATA_W{!(next_drive && !output_enable_n_in && !sleep_request_in
                                                 && write_n)}};
        end
    end
endmodule
`default_nettype wire

// file: core/sbsram_pkg.sv
`default_nettype none
package sbsram_pkg;
    localparam int ADDR_W = 19;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int SLEEP_ENTRY_CYCLES = 2;
    localparam int SLEEP_EXIT_CYCLES = 2;
    localparam logic [1:0] ORG_X36 = 2'h0;
    localparam logic [1:0] ORG_X18 = 2'h1;
    typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE} sbs_op_e;
endpackage
`default_nettype wire

// file: core/sbsram_lane_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-write decode; write controls active low as on the pins, lane enables out active high
module sbsram_lane_decode (
    input wire logic global_write_n_in,
    input wire logic byte_write_gate_in,
    input wire logic x18_mode_in,
    input wire logic [3:0] lane_write_n_in,
    output logic [3:0] lane_we_out,
    output logic write_n_out
);
    // Global write forces every lane; in x18 only lanes a and b exist
    always_comb begin
        if (!global_write_n_in) begin
            lane_we_out = x18_mode_in ? 4'h3 : 4'hF;
        end else if (!byte_write_gate_in) begin
            lane_we_out = ~lane_write_n_in & (x18_mode_in ? 4'h3 : 4'hF);
        end else begin
            lane_we_out = 4'h0;
        end
        write_n_out = ~(|lane_we_out);
    end
endmodule
`default_nettype wire

// file: tb/sbsram_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbsram_core_asserts (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic processor_addr_strobe_n_in,
    input wire logic controller_addr_strobe_n_in,
    input wire logic chip_sel_low_first_n_in,
    input wire logic chip_sel_pair_high_in,
    input wire logic chip_sel_pair_low_n_in,
    input wire logic output_enable_n_in,
    input wire logic global_write_n_in,
    input wire logic byte_write_gate_in,
    input wire logic sleep_request_in,
    input wire logic [sbsram_pkg::DATA_W-1:0] dq_oe_n_out,
    input wire logic asleep_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // Processor strobe with the first select off is a continue, not a deselect
    wire sel = !chip_sel_low_first_n_in && chip_sel_pair_high_in && !chip_sel_pair_low_n_in;
    wire quiet = processor_addr_strobe_n_in && controller_addr_strobe_n_in;
    wire desel = !sel && (!controller_addr_strobe_n_in || !(processor_addr_strobe_n_in || chip_sel_low_first_n_in));
    wire rd_go = sel && !processor_addr_strobe_n_in && !output_enable_n_in && !sleep_request_in && !asleep_out;
    // Continue beats must also decode as reads, or the pins rightly float
    wire calm = quiet && !output_enable_n_in && !sleep_request_in && global_write_n_in && byte_write_gate_in;
    chk_read_drive: assert property (rd_go ##1 calm [*2] |=> dq_oe_n_out[17:0] == 18'h0_0000)
        else $error("read beat not driven");
    chk_desel_float: assert property (desel ##1 quiet [*2] |=> &dq_oe_n_out)
        else $error("deselected device drove pins");
    chk_oe_float: assert property (output_enable_n_in [*3] |=> &dq_oe_n_out)
        else $error("pins driven with output enable off");
    chk_sleep_float: assert property (asleep_out |-> &dq_oe_n_out)
        else $error("pins driven while asleep");
    chk_sleep_entry: assert property (sleep_request_in [*2] |=> asleep_out)
        else $error("sleep entry late");
    chk_entry_delay: assert property ($rose(sleep_request_in) && !asleep_out |=> !asleep_out)
        else $error("sleep entry early");
    chk_wake_exit: assert property (!sleep_request_in [*2] |=> !asleep_out)
        else $error("wake late");
    chk_wake_delay: assert property ($fell(sleep_request_in) && asleep_out |=> asleep_out)
        else $error("wake early");
    cover property (rd_go);
    cover property (desel);
    cover property ($rose(asleep_out));
endmodule
bind sbsram_core sbsram_core_asserts u_chk (.*);
`default_nettype wire

// file: tb/sbsram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side controller: turns a bench command into strobe levels
module sbsram_ctrl_model (
    input wire logic clock_in,
    input wire logic [1:0] cmd_in,
    input wire logic sleep_request_in,
    output logic strobe_p_n_out,
    output logic strobe_c_n_out,
    output logic advance_n_out
);
    logic [1:0] wake = 2'h0;
    logic hush;
    // Reloads while sleep is requested, so strobes idle for two edges after the request drops
    always @(posedge clock_in) begin
        wake <= sleep_request_in ? 2'h2 : wake - {1'b0, wake != 2'h0};
    end
    // Commands: 1 processor start, 2 controller start, 3 advance, 0 suspend
    assign hush = !sleep_request_in && wake != 2'h0;
    assign strobe_p_n_out = hush || cmd_in != 2'h1;
    assign strobe_c_n_out = hush || cmd_in != 2'h2;
    assign advance_n_out = cmd_in != 2'h3;
endmodule
`default_nettype wire

// file: tb/sync_burst_sram_cmd_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_cmd_decode_tb_top;
    logic clock_in = 1'b0, rstn_in = 1'b0, x18_mode_in = 1'b0, burst_order_select_in = 1'b0;
    logic output_enable_n_in = 1'b0, sleep_request_in = 1'b0, global_write_n_in = 1'b1, byte_write_gate_in = 1'b1;
    logic chip_sel_low_first_n_in = 1'b0, chip_sel_pair_high_in = 1'b1, chip_sel_pair_low_n_in = 1'b0;
    logic [3:0] lane_write_n_in = 4'hf;
    logic [1:0] cmd = 2'h0;
    logic [18:0] address_in = '0;
    logic [35:0] dq_in = '0, dq_out, dq_oe_n_out;
    logic asleep_out, processor_addr_strobe_n_in, controller_addr_strobe_n_in, burst_advance_n_in;
    int err_total = 0, n_checks = 0, cycles = 0;
    // Rows: x18, global write, gate, lane enables, lanes expected written
    logic [10:0] rows [12] = '{11'h300, 11'h2f0, 11'h2e1, 11'h2d2, 11'h23c, 11'h20f, 11'h1ff,
        11'h6e1, 11'h6d2, 11'h6c3, 11'h4f3, 11'h7c0};
    sbsram_core DUT (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .x18_mode_in(x18_mode_in),
        .address_in(address_in),
        .processor_addr_strobe_n_in(processor_addr_strobe_n_in),
        .controller_addr_strobe_n_in(controller_addr_strobe_n_in),
        .burst_advance_n_in(burst_advance_n_in),
        .chip_sel_low_first_n_in(chip_sel_low_first_n_in),
        .chip_sel_pair_high_in(chip_sel_pair_high_in),
        .chip_sel_pair_low_n_in(chip_sel_pair_low_n_in),
        .global_write_n_in(global_write_n_in),
        .byte_write_gate_in(byte_write_gate_in),
        .lane_write_n_in(lane_write_n_in),
        .output_enable_n_in(output_enable_n_in),
        .sleep_request_in(sleep_request_in),
        .burst_order_select_in(burst_order_select_in),
        .dq_in(dq_in),
        .dq_out(dq_out),
        .dq_oe_n_out(dq_oe_n_out),
        .asleep_out(asleep_out)
    );
    sbsram_ctrl_model u_ctrl (.clock_in(clock_in), .cmd_in(cmd), .sleep_request_in(sleep_request_in),
        .strobe_p_n_out(processor_addr_strobe_n_in), .strobe_c_n_out(controller_addr_strobe_n_in),
        .advance_n_out(burst_advance_n_in));
    always #2.5 clock_in = ~clock_in;
    // Hang guard, far above the roughly 120 cycles the sequence needs
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 1000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One beat: drive just after an edge, hold through the next edge
    task automatic cyc(input logic [1:0] c, input logic [18:0] a, input logic [35:0] d, input logic g,
            input logic b, input logic [3:0] l);
        {cmd, address_in, dq_in, global_write_n_in, byte_write_gate_in, lane_write_n_in} = {c, a, d, g, b, l};
        @(posedge clock_in);
        #1;
    endtask
    // Start with write controls low, which must be ignored; data is out two edges later
    task automatic rd(input logic [18:0] a, input logic [35:0] exp, input logic [35:0] keep, input logic fl);
        cyc(2'h1, a, '0, 1'b0, 1'b0, 4'h0);
        cyc(2'h0, a, '0, 1'b1, 1'b1, 4'hf);
        cyc(2'h0, a, '0, 1'b1, 1'b1, 4'hf);
        chk("read data", exp & keep, dq_out & keep);
        chk("pin enable", {36{fl}}, dq_oe_n_out);
    endtask
    function automatic logic [35:0] lanes(input logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            lanes[i*9 +: 9] = {9{m[i]}};
        end
    endfunction
    initial begin
        repeat (3) @(posedge clock_in);
        chk("reset pins", '1, dq_oe_n_out);
        chk("reset sleep", '0, {35'h0, asleep_out});
        @(posedge clock_in);
        #1;
        rstn_in = 1'b1;
        // Fill a word with ones, write zeros under the row's controls, read back
        for (int r = 0; r < 12; r++) begin
            x18_mode_in = rows[r][10];
            cyc(2'h2, 19'h10 + 19'(r), '1, 1'b0, 1'b1, 4'hf);
            cyc(2'h2, 19'h10 + 19'(r), '0, rows[r][9], rows[r][8], rows[r][7:4]);
            rd(19'h10 + 19'(r), ~lanes(rows[r][3:0]), rows[r][10] ? 36'h0_0003_ffff : '1, 1'b0);
        end
        x18_mode_in = 1'b0;
        // Burst from offset 1: one suspended beat, then three advances
        for (int o = 0; o < 2; o++) begin
            burst_order_select_in = o[0];
            cyc(2'h2, 19'h41 + 19'(8 * o), 36'h10, 1'b0, 1'b1, 4'hf);
            cyc(2'h0, '0, 36'h11, 1'b0, 1'b1, 4'hf);
            for (int k = 1; k < 4; k++) begin
                cyc(2'h3, '0, 36'h11 + 36'(k), 1'b0, 1'b1, 4'hf);
            end
            rd(19'h41 + 19'(8 * o), 36'h11, '1, 1'b0);
            for (int k = 1; k < 4; k++) begin
                rd(19'h40 + 19'(8 * o) + 19'(o ? (1 ^ k) : ((1 + k) & 3)), 36'h11 + 36'(k), '1, 1'b0);
            end
        end
        for (int k = 0; k < 2; k++) begin
            {chip_sel_pair_high_in, chip_sel_pair_low_n_in} = k ? 2'h3 : 2'h0;
            rd(19'h41, '0, '0, 1'b1);
        end
        {chip_sel_pair_high_in, chip_sel_pair_low_n_in} = 2'h2;
        output_enable_n_in = 1'b1;
        rd(19'h41, '0, '0, 1'b1);
        output_enable_n_in = 1'b0;
        sleep_request_in = 1'b1;
        repeat (3) cyc(2'h0, '0, '0, 1'b1, 1'b1, 4'hf);
        chk("asleep", 36'h1, {35'h0, asleep_out});
        rd(19'h41, '0, '0, 1'b1);
        sleep_request_in = 1'b0;
        repeat (3) cyc(2'h0, '0, '0, 1'b1, 1'b1, 4'hf);
        chk("awake", '0, {35'h0, asleep_out});
        rd(19'h41, 36'h11, '1, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
